// ---- rtl/rawc_alarm_match.sv ----
// Purpose: Masked comparison of the time counters with one alarm set
// Assumes: BCD time bytes, alarm bytes carry the mask in bit 7
// Notes:   Purely combinational; the caller samples it on the second tick
`timescale 1ns/10ps
`default_nettype none
module rawc_alarm_match (
  input wire logic [7:0] alarm_sec,
  input wire logic [7:0] alarm_min,
  input wire logic [7:0] alarm_hour,
  input wire logic [7:0] alarm_day,
  input wire logic [7:0] time_sec,
  input wire logic [7:0] time_min,
  input wire logic [7:0] time_hour,
  input wire logic [7:0] time_day,
  input wire logic [7:0] time_date,
  output logic match
);
  import rawc_pkg::*;

  logic sec_ok;
  logic min_ok;
  logic hour_ok;
  logic day_ok;
  logic [7:0] day_or_date;

  // ---------------------------------------------------------------
  // Field compares; a set mask bit forces the field to agree
  // ---------------------------------------------------------------
  always_comb begin
    day_or_date = alarm_day[DAY_DATE_SEL_BIT] ? time_day : time_date;
    sec_ok = alarm_sec[ALARM_MASK_BIT] || (alarm_sec[6:0] == time_sec[6:0]);
    min_ok = alarm_min[ALARM_MASK_BIT] || (alarm_min[6:0] == time_min[6:0]);
    hour_ok = alarm_hour[ALARM_MASK_BIT] || (alarm_hour[6:0] == time_hour[6:0]);
    day_ok = alarm_day[ALARM_MASK_BIT] || (alarm_day[5:0] == day_or_date[5:0]);
    // Masks clear from seconds upward add one field each
    match = sec_ok && min_ok && hour_ok && day_ok;
  end

endmodule
`default_nettype wire

// ---- rtl/rawc_pkg.sv ----
// Purpose: Shared constants for the alarm, wave output, status and charger block
// Assumes: Byte-wide register port, one 125 MHz clock
// Notes:   Offsets are register indices on the byte-wide register port
package rawc_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_ALARM_FIRST = 8'h07;
  localparam logic [7:0] ADDR_ALARM_LAST = 8'h0d;
  localparam logic [7:0] ADDR_CONTROL = 8'h0e;
  localparam logic [7:0] ADDR_STATUS = 8'h0f;
  localparam logic [7:0] ADDR_CHARGER = 8'h10;

  // Alarm register slots, relative to the first alarm register
  localparam int ALARM_SLOTS = 7;
  localparam logic [2:0] SLOT_A1_SEC = 3'h0;
  localparam logic [2:0] SLOT_A1_MIN = 3'h1;
  localparam logic [2:0] SLOT_A1_HOUR = 3'h2;
  localparam logic [2:0] SLOT_A1_DAY = 3'h3;
  localparam logic [2:0] SLOT_A2_MIN = 3'h4;
  localparam logic [2:0] SLOT_A2_HOUR = 3'h5;
  localparam logic [2:0] SLOT_A2_DAY = 3'h6;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int ALARM_MASK_BIT = 7;
  localparam int DAY_DATE_SEL_BIT = 6;
  localparam int CTL_OSC_DISABLE_N = 7;
  localparam int CTL_BACKUP_OUT_EN = 5;
  localparam int CTL_RATE_HI = 4;
  localparam int CTL_RATE_LO = 3;
  localparam int CTL_IRQ_MODE = 2;
  localparam int CTL_A2_IRQ_EN = 1;
  localparam int CTL_A1_IRQ_EN = 0;
  localparam int STS_OSC_STOPPED = 7;
  localparam int STS_A2_FLAG = 1;
  localparam int STS_A1_FLAG = 0;

  // ---------------------------------------------------------------
  // Reset values and codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CONTROL_RESET = 8'h18;
  localparam logic [7:0] CONTROL_WRITE_MASK = 8'hbf;
  localparam logic [7:0] CHARGER_RESET = 8'h00;
  localparam logic [7:0] ALARM_RESET = 8'h00;
  localparam logic [3:0] CHARGER_KEY_OPEN = 4'ha;
  localparam logic [1:0] DIODE_NONE = 2'h1;
  localparam logic [1:0] DIODE_ONE = 2'h2;
  localparam logic [1:0] RESISTOR_OFF = 2'h0;
  localparam logic [7:0] SECONDS_ZERO = 8'h00;

  // Wave divider taps on a counter stepped at each oscillator edge
  localparam int WAVE_TAP_1HZ = 15;
  localparam int WAVE_TAP_4K = 3;
  localparam int WAVE_TAP_8K = 2;
  localparam int WAVE_TAP_32K = 0;
  localparam int WAVE_DIV_WIDTH = 16;

endpackage

// ---- rtl/rawc_top.sv ----
// Purpose: Alarms, wave/interrupt pin, status flags and charger setup of an RTC
// Assumes: Register port and time counters share the 125 MHz clock
// Notes:   Supply sense inputs are asynchronous and pass two flip-flops
`timescale 1ns/10ps
`default_nettype none
module rawc_top (
  input wire logic clock,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic reg_write,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic second_tick,
  input wire logic osc_tick,
  input wire logic [7:0] time_sec,
  input wire logic [7:0] time_min,
  input wire logic [7:0] time_hour,
  input wire logic [7:0] time_day,
  input wire logic [7:0] time_date,
  input wire logic supply_lost,
  input wire logic main_supply_ok,
  output logic osc_run,
  output logic wave_irq_out,
  output logic wave_irq_oe,
  output logic charger_enable,
  output logic charger_diode,
  output logic [1:0] charger_resistor
);
  import rawc_pkg::*;

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  logic [7:0] alarm_regs [ALARM_SLOTS];
  logic osc_disable_n;
  logic backup_output_enable;
  logic rate_select_hi;
  logic rate_select_lo;
  logic irq_mode_select;
  logic alarm_one_irq_enable;
  logic alarm_two_irq_enable;
  logic alarm_one_flag;
  logic alarm_two_flag;
  logic osc_stopped_flag;
  logic [3:0] charger_key;
  logic [1:0] diode_select;
  logic [1:0] resistor_select;

  logic wr_control;
  logic wr_status;
  logic wr_charger;
  logic a1_match;
  logic a2_match;
  logic wave_level;
  logic osc_disable_n_d;
  logic osc_stop_event;
  logic lost_meta;
  logic lost_sync;
  logic lost_sync_d;
  logic main_meta;
  logic main_sync;
  logic irq_active;
  logic next_charger_on;

  // Write decodes
  assign wr_control = reg_write && (reg_addr == ADDR_CONTROL);
  assign wr_status = reg_write && (reg_addr == ADDR_STATUS);
  assign wr_charger = reg_write && (reg_addr == ADDR_CHARGER);

  // ---------------------------------------------------------------
  // Alarm register storage
  // ---------------------------------------------------------------
  // One slot per alarm byte, indexed by offset from the first
  generate
    for (genvar i = 0; i < ALARM_SLOTS; i++) begin : g_alarm
      always_ff @(posedge clock) begin
        if (reset) begin
          alarm_regs[i] <= ALARM_RESET;
        end else if (reg_write && (reg_addr == ADDR_ALARM_FIRST + 8'(i))) begin
          alarm_regs[i] <= reg_wdata;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------
  // Power-up state: oscillator on, 32 kHz wave, interrupts off
  always_ff @(posedge clock) begin
    if (reset) begin
      osc_disable_n <= CONTROL_RESET[CTL_OSC_DISABLE_N];
      backup_output_enable <= CONTROL_RESET[CTL_BACKUP_OUT_EN];
      rate_select_hi <= CONTROL_RESET[CTL_RATE_HI];
      rate_select_lo <= CONTROL_RESET[CTL_RATE_LO];
      irq_mode_select <= CONTROL_RESET[CTL_IRQ_MODE];
      alarm_two_irq_enable <= CONTROL_RESET[CTL_A2_IRQ_EN];
      alarm_one_irq_enable <= CONTROL_RESET[CTL_A1_IRQ_EN];
    end else if (wr_control) begin
      osc_disable_n <= reg_wdata[CTL_OSC_DISABLE_N];
      backup_output_enable <= reg_wdata[CTL_BACKUP_OUT_EN];
      rate_select_hi <= reg_wdata[CTL_RATE_HI];
      rate_select_lo <= reg_wdata[CTL_RATE_LO];
      irq_mode_select <= reg_wdata[CTL_IRQ_MODE];
      alarm_two_irq_enable <= reg_wdata[CTL_A2_IRQ_EN];
      alarm_one_irq_enable <= reg_wdata[CTL_A1_IRQ_EN];
    end
  end

  // ---------------------------------------------------------------
  // Charger register and decode
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      {charger_key, diode_select, resistor_select} <= CHARGER_RESET;
    end else if (wr_charger) begin
      {charger_key, diode_select, resistor_select} <= reg_wdata;
    end
  end

  // A wrong key, a bad diode code or no resistor all leave it off
  assign next_charger_on = (charger_key == CHARGER_KEY_OPEN)
                        && ((diode_select == DIODE_NONE) || (diode_select == DIODE_ONE))
                        && (resistor_select != RESISTOR_OFF);

  always_ff @(posedge clock) begin
    if (reset) begin
      charger_enable <= 1'b0;
      charger_diode <= 1'b0;
      charger_resistor <= RESISTOR_OFF;
    end else begin
      charger_enable <= next_charger_on;
      charger_diode <= next_charger_on && (diode_select == DIODE_ONE);
      charger_resistor <= next_charger_on ? resistor_select : RESISTOR_OFF;
    end
  end

  // ---------------------------------------------------------------
  // Supply sense synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      lost_meta <= 1'b0;
      lost_sync <= 1'b0;
      lost_sync_d <= 1'b0;
      main_meta <= 1'b1;
      main_sync <= 1'b1;
    end else begin
      lost_meta <= supply_lost;
      lost_sync <= lost_meta;
      lost_sync_d <= lost_sync;
      main_meta <= main_supply_ok;
      main_sync <= main_meta;
    end
  end

  // ---------------------------------------------------------------
  // Alarm compare and flags
  // ---------------------------------------------------------------
  rawc_alarm_match u_alarm_one (
    .alarm_sec(alarm_regs[SLOT_A1_SEC]),
    .alarm_min(alarm_regs[SLOT_A1_MIN]),
    .alarm_hour(alarm_regs[SLOT_A1_HOUR]),
    .alarm_day(alarm_regs[SLOT_A1_DAY]),
    .time_sec(time_sec),
    .time_min(time_min),
    .time_hour(time_hour),
    .time_day(time_day),
    .time_date(time_date),
    .match(a1_match)
  );

  // Alarm two has no seconds byte: an unmasked zero forces seconds 00
  rawc_alarm_match u_alarm_two (
    .alarm_sec(SECONDS_ZERO),
    .alarm_min(alarm_regs[SLOT_A2_MIN]),
    .alarm_hour(alarm_regs[SLOT_A2_HOUR]),
    .alarm_day(alarm_regs[SLOT_A2_DAY]),
    .time_sec(time_sec),
    .time_min(time_min),
    .time_hour(time_hour),
    .time_day(time_day),
    .time_date(time_date),
    .match(a2_match)
  );

  // Set wins over a clearing write in the same cycle
  always_ff @(posedge clock) begin
    if (reset) begin
      alarm_one_flag <= 1'b0;
      alarm_two_flag <= 1'b0;
    end else begin
      alarm_one_flag <= (second_tick && a1_match)
                     || (alarm_one_flag && !(wr_status && !reg_wdata[STS_A1_FLAG]));
      alarm_two_flag <= (second_tick && a2_match)
                     || (alarm_two_flag && !(wr_status && !reg_wdata[STS_A2_FLAG]));
    end
  end

  // Stop edge: software stopping the oscillator or both supplies gone
  assign osc_stop_event = (osc_disable_n && !osc_disable_n_d) || (lost_sync && !lost_sync_d);

  // Reset counts as a first power-up, so the flag starts set
  always_ff @(posedge clock) begin
    if (reset) begin
      osc_disable_n_d <= 1'b0;
      osc_stopped_flag <= 1'b1;
    end else begin
      osc_disable_n_d <= osc_disable_n;
      osc_stopped_flag <= osc_stop_event
                       || (osc_stopped_flag && !(wr_status && !reg_wdata[STS_OSC_STOPPED]));
    end
  end

  // ---------------------------------------------------------------
  // Wave / interrupt pin
  // ---------------------------------------------------------------
  rawc_wave_div #(
    .WIDTH(WAVE_DIV_WIDTH)
  ) u_wave (
    .clock(clock),
    .reset(reset),
    .osc_tick(osc_tick),
    .osc_running(!osc_disable_n),
    .rate({rate_select_hi, rate_select_lo}),
    .wave(wave_level)
  );

  // Level stays asserted as long as the flag does, so no pulse is lost
  assign irq_active = (alarm_one_flag && alarm_one_irq_enable)
                   || (alarm_two_flag && alarm_two_irq_enable);

  always_ff @(posedge clock) begin
    if (reset) begin
      wave_irq_out <= 1'b1;
      wave_irq_oe <= 1'b1;
      osc_run <= 1'b1;
    end else begin
      wave_irq_out <= irq_mode_select ? !irq_active : wave_level;
      wave_irq_oe <= main_sync || backup_output_enable;
      osc_run <= !osc_disable_n;
    end
  end

  // ---------------------------------------------------------------
  // Register readback, one cycle after the address
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_addr >= ADDR_ALARM_FIRST && reg_addr <= ADDR_ALARM_LAST) begin
      reg_rdata <= alarm_regs[3'(reg_addr - ADDR_ALARM_FIRST)];
    end else begin
      case (reg_addr)
        ADDR_CONTROL: reg_rdata <= {osc_disable_n, 1'b0, backup_output_enable, rate_select_hi,
                                    rate_select_lo, irq_mode_select, alarm_two_irq_enable,
                                    alarm_one_irq_enable};
        ADDR_STATUS: reg_rdata <= {osc_stopped_flag, 5'h00, alarm_two_flag, alarm_one_flag};
        ADDR_CHARGER: reg_rdata <= {charger_key, diode_select, resistor_select};
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_stop_edge;
    !osc_disable_n ##1 osc_disable_n;
  endsequence

  property p_a1_set;
    @(posedge clock) disable iff (reset) (second_tick && a1_match) |=> alarm_one_flag;
  endproperty
  a_a1_set: assert property (p_a1_set) else $error("alarm one match did not set flag");

  property p_a2_minute;
    @(posedge clock) disable iff (reset)
      (second_tick && alarm_regs[SLOT_A2_MIN][7] && alarm_regs[SLOT_A2_HOUR][7] && alarm_regs[SLOT_A2_DAY][7]
       && time_sec == SECONDS_ZERO) |=> alarm_two_flag;
  endproperty
  a_a2_minute: assert property (p_a2_minute) else $error("alarm two missed seconds zero");

  property p_flag_no_tick;
    @(posedge clock) disable iff (reset) (!second_tick && !alarm_one_flag) |=> !alarm_one_flag;
  endproperty
  a_flag_no_tick: assert property (p_flag_no_tick) else $error("alarm one flag set off the tick");

  property p_a1_clear;
    @(posedge clock) disable iff (reset)
      (wr_status && !reg_wdata[STS_A1_FLAG] && !(second_tick && a1_match)) |=> !alarm_one_flag;
  endproperty
  a_a1_clear: assert property (p_a1_clear) else $error("zero write did not clear alarm one flag");

  property p_osf_set;
    @(posedge clock) disable iff (reset) s_stop_edge |=> osc_stopped_flag;
  endproperty
  a_osf_set: assert property (p_osf_set) else $error("stop edge did not set stop flag");

  property p_osf_hold;
    @(posedge clock) disable iff (reset)
      (osc_stopped_flag && !(wr_status && !reg_wdata[STS_OSC_STOPPED])) |=> osc_stopped_flag;
  endproperty
  a_osf_hold: assert property (p_osf_hold) else $error("stop flag dropped without zero write");

  property p_irq_pin;
    @(posedge clock) disable iff (reset) (irq_mode_select && irq_active) |=> !wave_irq_out;
  endproperty
  a_irq_pin: assert property (p_irq_pin) else $error("enabled alarm did not pull pin low");

  property p_irq_quiet;
    @(posedge clock) disable iff (reset)
      (irq_mode_select && !alarm_one_irq_enable && !alarm_two_irq_enable) |=> wave_irq_out;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("disabled alarm drove pin");

  property p_charger;
    @(posedge clock) disable iff (reset) charger_enable |-> $past(charger_key) == CHARGER_KEY_OPEN;
  endproperty
  a_charger: assert property (p_charger) else $error("charger on without key");

  property p_oe_off;
    @(posedge clock) disable iff (reset) (!main_sync && !backup_output_enable) |=> !wave_irq_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("pin driven on backup without enable");

  property p_wave_frozen;
    @(posedge clock) disable iff (reset)
      (osc_disable_n && !irq_mode_select) [*2] |=> $stable(wave_level);
  endproperty
  a_wave_frozen: assert property (p_wave_frozen) else $error("wave moved with oscillator off");

endmodule
`default_nettype wire

// ---- rtl/rawc_wave_div.sv ----
// Purpose: Square wave divider fed by oscillator edge pulses
// Assumes: osc_tick pulses once per oscillator edge, same clock domain
// Notes:   Counter holds while the oscillator is stopped
`timescale 1ns/10ps
`default_nettype none
module rawc_wave_div #(
  parameter int WIDTH = rawc_pkg::WAVE_DIV_WIDTH
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic osc_tick,
  input wire logic osc_running,
  input wire logic [1:0] rate,
  output logic wave
);
  import rawc_pkg::*;

  logic [WIDTH-1:0] count;

  // Refused at elaboration: the 1 Hz tap needs the counter's top bit
  if (WIDTH <= WAVE_TAP_1HZ) begin : g_width_check
    $error("rawc_wave_div: WIDTH too small for the 1 Hz tap");
  end

  // ---------------------------------------------------------------
  // Edge counter; frozen when the oscillator is off
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      count <= '0;
    end else if (osc_tick && osc_running) begin
      count <= count + 1'b1;
    end
  end

  // Tap select per rate code
  always_comb begin
    case (rate)
      2'h0: wave = count[WAVE_TAP_1HZ];
      2'h1: wave = count[WAVE_TAP_4K];
      2'h2: wave = count[WAVE_TAP_8K];
      default: wave = count[WAVE_TAP_32K];
    endcase
  end

endmodule
`default_nettype wire

// ---- verification/rawc_host_model.sv ----
// Purpose: Host side of the register port, writes and reads bytes
// Assumes: Requests change at the falling clock edge
// Notes:   Write data is scrambled while no write is pending
`timescale 1ns/10ps
`default_nettype none
module rawc_host_model (
  input wire logic clock,
  input wire logic [7:0] reg_rdata,
  output logic [7:0] reg_addr,
  output logic reg_write,
  output logic [7:0] reg_wdata
);
  // ---------------------------------------------------------------
  // Register access
  // ---------------------------------------------------------------
  initial begin
    reg_addr = 8'h00;
    reg_write = 1'b0;
    reg_wdata = 8'h00;
  end

  // One-cycle strobe; stale data inverted so it never passes for valid
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clock);
    reg_addr = addr;
    reg_wdata = data;
    reg_write = 1'b1;
    @(negedge clock);
    reg_write = 1'b0;
    reg_wdata = ~data;
  endtask

  // Readback is registered, so sample one cycle after the address
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    @(negedge clock);
    reg_addr = addr;
    @(negedge clock);
    data = reg_rdata;
  endtask
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
// Purpose: Self-checking bench for alarms, wave pin, flags and charger
// Assumes: Inputs driven at the falling edge, 125 MHz clock
// Notes:   Wave rates checked by counting pin toggles per tick count
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import rawc_pkg::*;
  logic clock, reset, reg_write, second_tick, osc_tick, supply_lost, main_supply_ok;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, time_sec, time_min, time_hour, time_day, time_date, rd;
  logic osc_run, wave_irq_out, wave_irq_oe, charger_enable, charger_diode;
  logic [1:0] charger_resistor;
  int bad_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  int toggles;
  // Charger rows: written byte, then enable, diode, resistor
  logic [11:0] crow [11] = '{12'ha59, 12'ha9d, 12'ha6a, 12'haae, 12'ha7b, 12'habf,
                             12'ha10, 12'had0, 12'ha40, 12'h550, 12'h250};
  // Alarm rows: seven alarm bytes, time sec/min/hour/day/date, expected flags
  logic [97:0] arow [12] = '{
    {56'h80808080808080, 40'h1200000101, 2'h1}, {56'h80808080808080, 40'h0000000101, 2'h3},
    {56'h12808080348080, 40'h1234000101, 2'h1}, {56'h12808080348080, 40'h1334000101, 2'h0},
    {56'h12348080341280, 40'h1235120101, 2'h0}, {56'h12341280341280, 40'h1234120101, 2'h1},
    {56'h00341215341215, 40'h0034120315, 2'h3}, {56'h00341243341243, 40'h0034120315, 2'h3},
    {56'h00341245341245, 40'h0034120315, 2'h0}, {56'h00341203341203, 40'h0034120315, 2'h0},
    {56'h80808080348080, 40'h0034120315, 2'h3}, {56'h80808080341280, 40'h0034130315, 2'h1}};

  rawc_top i_rawc_top (.clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_write(reg_write),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .second_tick(second_tick), .osc_tick(osc_tick),
    .time_sec(time_sec), .time_min(time_min), .time_hour(time_hour), .time_day(time_day),
    .time_date(time_date), .supply_lost(supply_lost), .main_supply_ok(main_supply_ok), .osc_run(osc_run),
    .wave_irq_out(wave_irq_out), .wave_irq_oe(wave_irq_oe), .charger_enable(charger_enable),
    .charger_diode(charger_diode), .charger_resistor(charger_resistor));
  rawc_host_model i_rawc_host_model (.clock(clock), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_write(reg_write), .reg_wdata(reg_wdata));

  // ---------------------------------------------------------------
  // Clock, timeout and helpers
  // ---------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // Whole run needs about 34000 cycles; a hang stops well past that
  always @(posedge clock) begin
    cycles++;
    if (cycles == 50000) begin
      bad_count++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    if (bad_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] expd);
    cmp_count++;
    if (seen !== expd) begin
      bad_count++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, expd);
    end
  endtask

  task automatic rd_chk(input logic [7:0] addr, input logic [7:0] expd);
    i_rawc_host_model.read_reg(addr, rd);
    check(rd, expd);
  endtask

  task automatic wait_cycles(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic tick();
    @(negedge clock);
    second_tick = 1'b1;
    @(negedge clock);
    second_tick = 1'b0;
  endtask

  task automatic reset_dut();
    reset = 1'b1;
    repeat (6) @(negedge clock);
    reset = 1'b0;
  endtask

  task automatic check_resets();
    rd_chk(ADDR_CONTROL, 8'h18);
    rd_chk(ADDR_STATUS, 8'h80);
    rd_chk(ADDR_CHARGER, 8'h00);
    check(8'({osc_run, charger_enable, wave_irq_oe}), 8'h05);
  endtask

  // Holds osc_tick high for n cycles and counts pin changes
  task automatic run_wave(input int n);
    logic last;
    wait_cycles(3);
    last = wave_irq_out;
    toggles = 0;
    osc_tick = 1'b1;
    for (int c = 0; c < n + 4; c++) begin
      @(negedge clock);
      if (c == n - 1) osc_tick = 1'b0;
      if (wave_irq_out !== last) toggles++;
      last = wave_irq_out;
    end
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {reset, second_tick, osc_tick, supply_lost} = 4'h8;
    main_supply_ok = 1'b1;
    {time_sec, time_min, time_hour, time_day, time_date} = 40'h0;
    reset_dut();
    check_resets();
    // Charger table
    foreach (crow[i]) begin
      i_rawc_host_model.write_reg(ADDR_CHARGER, crow[i][11:4]);
      wait_cycles(2);
      check(8'({charger_enable, charger_diode, charger_resistor}), 8'(crow[i][3:0]));
      rd_chk(ADDR_CHARGER, crow[i][11:4]);
    end
    // Alarm table, enables off so flags alone are seen
    foreach (arow[i]) begin
      for (int k = 0; k < 7; k++) i_rawc_host_model.write_reg(ADDR_ALARM_FIRST + 8'(k), arow[i][97-8*k -: 8]);
      {time_sec, time_min, time_hour, time_day, time_date} = arow[i][41:2];
      i_rawc_host_model.write_reg(ADDR_STATUS, 8'h00);
      rd_chk(ADDR_STATUS, 8'h00);
      tick();
      rd_chk(ADDR_STATUS, {6'h00, arow[i][1:0]});
    end
    // Interrupt pin: alarm one matches every second from here
    i_rawc_host_model.write_reg(ADDR_CONTROL, 8'h05);
    i_rawc_host_model.write_reg(ADDR_STATUS, 8'h00);
    wait_cycles(3);
    check(8'(wave_irq_out), 8'h01);
    tick();
    wait_cycles(2);
    check(8'(wave_irq_out), 8'h00);
    wait_cycles(20);
    check(8'(wave_irq_out), 8'h00);
    i_rawc_host_model.write_reg(ADDR_STATUS, 8'h83);
    wait_cycles(3);
    check(8'(wave_irq_out), 8'h00);
    i_rawc_host_model.write_reg(ADDR_STATUS, 8'h00);
    wait_cycles(3);
    check(8'(wave_irq_out), 8'h01);
    i_rawc_host_model.write_reg(ADDR_CONTROL, 8'h06);
    tick();
    wait_cycles(3);
    check(8'(wave_irq_out), 8'h01);
    i_rawc_host_model.write_reg(ADDR_CONTROL, 8'h04);
    tick();
    wait_cycles(3);
    check(8'(wave_irq_out), 8'h01);
    rd_chk(ADDR_STATUS, 8'h01);
    // Alarm two on hours and minutes drives the pin through its own enable
    time_hour = 8'h12;
    i_rawc_host_model.write_reg(ADDR_CONTROL, 8'h06);
    tick();
    wait_cycles(2);
    check(8'(wave_irq_out), 8'h00);
    rd_chk(ADDR_STATUS, 8'h03);
    // Wave rates: toggles equal ticks divided by 2 to the tap
    for (int r = 0; r < 4; r++) begin
      i_rawc_host_model.write_reg(ADDR_CONTROL, 8'(r << 3));
      run_wave(r == 0 ? 32768 : 64);
      check(8'(toggles), r == 0 ? 8'h01 : 8'(64 >> (r == 1 ? 3 : r == 2 ? 2 : 0)));
    end
    // Oscillator off: frozen wave, stop flag, reserved bit reads zero
    i_rawc_host_model.write_reg(ADDR_STATUS, 8'h00);
    i_rawc_host_model.write_reg(ADDR_CONTROL, 8'hfb);
    rd_chk(ADDR_CONTROL, 8'hbb);
    check(8'(osc_run), 8'h00);
    run_wave(64);
    check(8'(toggles), 8'h00);
    rd_chk(ADDR_STATUS, 8'h80);
    i_rawc_host_model.write_reg(ADDR_STATUS, 8'h80);
    rd_chk(ADDR_STATUS, 8'h80);
    i_rawc_host_model.write_reg(ADDR_CONTROL, 8'h18);
    i_rawc_host_model.write_reg(ADDR_STATUS, 8'h00);
    rd_chk(ADDR_STATUS, 8'h00);
    // Supply loss sets the stop flag; backup enable keeps the pin
    supply_lost = 1'b1;
    wait_cycles(6);
    supply_lost = 1'b0;
    rd_chk(ADDR_STATUS, 8'h80);
    main_supply_ok = 1'b0;
    wait_cycles(5);
    check(8'(wave_irq_oe), 8'h00);
    i_rawc_host_model.write_reg(ADDR_CONTROL, 8'h38);
    wait_cycles(3);
    check(8'(wave_irq_oe), 8'h01);
    main_supply_ok = 1'b1;
    // Unmapped place, then a second reset in mid-run
    i_rawc_host_model.write_reg(8'h11, 8'hff);
    rd_chk(8'h11, 8'h00);
    i_rawc_host_model.write_reg(ADDR_CHARGER, 8'ha5);
    reset_dut();
    check_resets();
    give_verdict();
  end
endmodule
`default_nettype wire
